// [mspi_pkg.sv]
/*
  shared constants, register map and frame carrier for the modem spi target port.
  assumes a single 25 mhz clock with synchronous active-high reset.
*/
// Operation
// - cs rise latches last 24/32 shifted bits
// - only mode 0/1 and mode 1/0 supported
// - sdo changes on sclk rise, cs fall
// - sdo returns previous frame's answer
// - write echo repeats received crc byte
// - bit 23 direction, 22:16 address, 15:0 data
// - crc byte uses x^8+x^2+x+1
// - bad crc write is not applied but still echoed
// - bad crc read answers 0x80000000, no pop
// - control bit 2 selects level or pulse
// - control bit 3 selects interrupt polarity
// - mask bit one blocks its event
// - level mode latched until status read
// - pulse mode: one pulse per new event
// - control resets to 0x8042
// - bits 15:13 select watchdog timeout
// - control bit 12 enables watchdog, default off
// - writing 0x0001 to reset restores defaults
`default_nettype none
package mspi_pkg;
  // register indices
  localparam logic [6:0] ADDR_PORT_CONTROL  = 7'h02;
  localparam logic [6:0] ADDR_SOFT_RESET    = 7'h07;
  localparam logic [6:0] ADDR_EVENT_STATUS  = 7'h20;
  localparam logic [6:0] ADDR_EVENT_MASK    = 7'h21;
  localparam logic [6:0] ADDR_LINE_CONTROL  = 7'h22;
  localparam logic [6:0] ADDR_TX_QUEUE      = 7'h23;
  localparam logic [6:0] ADDR_RX_QUEUE      = 7'h24;
  localparam logic [6:0] ADDR_THRESHOLDS    = 7'h25;
  localparam logic [6:0] ADDR_BABBLE_LIMIT  = 7'h27;
  // reset values
  localparam logic [15:0] PORT_CONTROL_RESET = 16'h8042;
  localparam logic [15:0] SOFT_RESET_KEY     = 16'h0001;
  localparam logic [15:0] ZERO_RESET         = 16'h0000;
  localparam logic [15:0] MASK_RESET         = 16'hFFFF;
  // control field positions
  localparam int CTL_SDO_B   = 0;
  localparam int CTL_SDO_Z   = 1;
  localparam int CTL_LEVEL   = 2;
  localparam int CTL_POL     = 3;
  localparam int CTL_CRC_EN  = 4;
  localparam int CTL_WD_EN   = 12;
  localparam int CTL_WATCHDOG_TIMEOUT_SELECT_LO = 13;
  localparam logic [15:0] CTL_WRITABLE = 16'hF05F;
  // status bit of the watchdog and crc errors
  localparam int ST_WDT = 9;
  localparam int ST_CRC = 8;
  // frame layout
  localparam int FRAME_BITS     = 24;
  localparam int CRC_FRAME_BITS = 32;
  localparam int DIR_BIT        = 23;
  localparam logic [7:0]  CRC_POLY     = 8'h07;
  localparam logic [31:0] BAD_CRC_WORD = 32'h80000000;
  // watchdog timing: 25 mhz clock, periods in ms
  localparam int CLK_HZ = 25_000_000;
  localparam int WD_MS_50 = 50;
  localparam int WD_MS_100 = 100;
  localparam int WD_MS_500 = 500;
  localparam int WD_MS_1000 = 1000;
  localparam int WD_MS_2000 = 2000;
  localparam int WD_MS_3000 = 3000;
  localparam int WD_MS_4000 = 4000;
  localparam int WD_MS_5000 = 5000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  // decoded frame carrier
  typedef struct packed {
    logic       read;
    logic [6:0] addr;
    logic [15:0] data;
    logic [7:0] crc;
  } mspi_frame_type;
endpackage
`default_nettype wire

// [mspi_crc8.sv]
/*
  crc8 over a 24-bit word, polynomial x^8+x^2+x+1, msb first, zero seed.
  assumes purely combinational use.
*/
`default_nettype none
module mspi_crc8 (
  input  wire logic [23:0] word,
  output logic      [7:0]  crc
);
  // serial form unrolled by a loop; cheap at 24 bits
  always_comb begin
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      if (c[7] ^ word[i]) begin
        c = {c[6:0], 1'b0} ^ mspi_pkg::CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc = c;
  end
endmodule
`default_nettype wire

// [mspi_port.sv]
/*
  spi target port with register map, interrupt pin and serial watchdog.
  assumes sclk, cs_n and sdi arrive from outside and are synchronised here;
  modem datapath connects through event, queue and control ports.
  sdo timing needs an sclk half period of at least four clock cycles.
*/
`default_nettype none
module mspi_port #(
  parameter int WD_SCALE = mspi_pkg::CYC_PER_MS // cycles per ms, shorten in sim
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe,
  output logic             irq,
  input  wire logic [15:0] event_set,
  input  wire logic [15:0] event_live,
  input  wire logic [15:0] rx_queue_data,
  output logic             rx_queue_pop,
  output logic             tx_queue_push,
  output logic      [15:0] tx_queue_data,
  output logic             queue_flush,
  output logic      [15:0] line_control,
  output logic      [15:0] queue_thresholds,
  output logic      [15:0] babble_guard_limit,
  output logic      [15:0] port_control
);
  // synchronisers, two flops each; pins are asynchronous to clk
  // cs resets high so that no false select edge follows reset
  logic [1:0] sclk_s, cs_s, sdi_s; // two-flop chains
  logic       sclk_d, cs_d;        // delayed copies for edge detect
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_s <= 2'b00;
      cs_s   <= 2'b11;
      sdi_s  <= 2'b00;
      sclk_d <= 1'b0;
      cs_d   <= 1'b1;
    end else begin
      sclk_s <= {sclk_s[0], sclk};
      cs_s   <= {cs_s[0], cs_n};
      sdi_s  <= {sdi_s[0], sdi};
      sclk_d <= sclk_s[1];
      cs_d   <= cs_s[1];
    end
  end
  // edges appear two to three cycles after the pin moves
  logic sclk_now, cs_now, sclk_rise, sclk_fall, cs_fall, cs_rise;
  assign sclk_now  = sclk_s[1];
  assign cs_now    = cs_s[1];
  assign sclk_rise = sclk_now & ~sclk_d;
  assign sclk_fall = ~sclk_now & sclk_d;
  assign cs_fall   = ~cs_now & cs_d;
  assign cs_rise   = cs_now & ~cs_d;

  // idle level at cs fall picks the mode; both modes sample on the falling edge
  // mode 0/1 idles low: its first rise only launches the bit already shown at
  // cs fall, so that rise must not shift; mode 1/0 samples before any rise
  logic lead_skip; // first rise of the frame still to be skipped
  always_ff @(posedge clk) begin
    if (rst) begin
      lead_skip <= 1'b0;
    end else if (cs_fall) begin
      lead_skip <= ~sclk_now;
    end else if (!cs_now && sclk_rise) begin
      lead_skip <= 1'b0;
    end
  end

  // input shift register; older bits fall off the top
  // sdi is taken on the synchronised falling edge in both modes
  logic [31:0] shift_in;
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_in <= 32'h00000000;
    end else if (!cs_now && sclk_fall) begin
      shift_in <= {shift_in[30:0], sdi_s[1]};
    end
  end

  // frame decode: right justified, crc byte last
  logic                   crc_on;
  mspi_pkg::mspi_frame_type frame;
  logic [7:0]             crc_calc;
  logic                   crc_ok;
  assign crc_on = port_control[mspi_pkg::CTL_CRC_EN];
  // crc off: an empty check byte is padded so one layout serves both lengths
  always_comb begin
    if (crc_on) begin
      frame = shift_in;
    end else begin
      frame = {shift_in[23:0], 8'h00};
    end
  end
  // check byte over the 24 command bits of the incoming word
  mspi_crc8 u_crc (
    .word (frame[31:8]),
    .crc  (crc_calc)
  );
  assign crc_ok = !crc_on || (crc_calc == frame.crc);

  // frame acceptance strobes
  // a bad check byte still reaches the crc status bit through bad_any
  logic do_write, do_read, bad_read, bad_any;
  assign do_write = cs_rise && !frame.read && crc_ok;
  assign do_read  = cs_rise && frame.read && crc_ok;
  assign bad_read = cs_rise && frame.read && !crc_ok;
  assign bad_any  = cs_rise && !crc_ok;
  // soft reset lands one edge after cs rise, like any other write
  logic soft_rst;
  assign soft_rst = do_write && frame.addr == mspi_pkg::ADDR_SOFT_RESET
                    && frame.data == mspi_pkg::SOFT_RESET_KEY;

  // writable registers
  // soft reset shares the reset branch so every register returns to default
  // reserved control bits read back zero through the writable mask
  logic [15:0] event_mask;
  always_ff @(posedge clk) begin
    if (rst || soft_rst) begin
      port_control       <= mspi_pkg::PORT_CONTROL_RESET;
      event_mask         <= mspi_pkg::MASK_RESET;
      line_control       <= mspi_pkg::ZERO_RESET;
      queue_thresholds   <= mspi_pkg::ZERO_RESET;
      babble_guard_limit <= mspi_pkg::ZERO_RESET;
    end else if (do_write) begin
      case (frame.addr)
        mspi_pkg::ADDR_PORT_CONTROL:
          port_control <= frame.data & mspi_pkg::CTL_WRITABLE;
        mspi_pkg::ADDR_EVENT_MASK:   event_mask         <= frame.data;
        mspi_pkg::ADDR_LINE_CONTROL: line_control       <= frame.data;
        mspi_pkg::ADDR_THRESHOLDS:   queue_thresholds   <= frame.data;
        mspi_pkg::ADDR_BABBLE_LIMIT: babble_guard_limit <= frame.data;
        default: ; // reserved offsets ignored
      endcase
    end
  end

  // queue strobes, one cycle
  // the pop follows only a good read, so a bad check byte keeps the entry
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_queue_push <= 1'b0;
      tx_queue_data <= 16'h0000;
      rx_queue_pop  <= 1'b0;
      queue_flush   <= 1'b0;
    end else begin
      tx_queue_push <= do_write && frame.addr == mspi_pkg::ADDR_TX_QUEUE;
      if (do_write && frame.addr == mspi_pkg::ADDR_TX_QUEUE) begin
        tx_queue_data <= frame.data;
      end
      rx_queue_pop  <= do_read && frame.addr == mspi_pkg::ADDR_RX_QUEUE;
      queue_flush   <= soft_rst;
    end
  end

  // watchdog: restart per accepted frame, expiry sets status
  // a write or read restarts the count, so a busy host never trips it
  // counter width covers the longest setting at the full clock rate
  logic [31:0] wd_count;
  logic [31:0] wd_limit;
  logic        wd_fire;
  always_comb begin
    case (port_control[15:13])
      3'h0:    wd_limit = 32'(mspi_pkg::WD_MS_50 * WD_SCALE);
      3'h1:    wd_limit = 32'(mspi_pkg::WD_MS_100 * WD_SCALE);
      3'h2:    wd_limit = 32'(mspi_pkg::WD_MS_500 * WD_SCALE);
      3'h3:    wd_limit = 32'(mspi_pkg::WD_MS_1000 * WD_SCALE);
      3'h4:    wd_limit = 32'(mspi_pkg::WD_MS_2000 * WD_SCALE);
      3'h5:    wd_limit = 32'(mspi_pkg::WD_MS_3000 * WD_SCALE);
      3'h6:    wd_limit = 32'(mspi_pkg::WD_MS_4000 * WD_SCALE);
      default: wd_limit = 32'(mspi_pkg::WD_MS_5000 * WD_SCALE);
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst || !port_control[mspi_pkg::CTL_WD_EN] || do_write || do_read) begin
      wd_count <= 32'h00000000;
      wd_fire  <= 1'b0;
    end else if (wd_count >= wd_limit - 32'h00000001) begin
      wd_count <= 32'h00000000;
      wd_fire  <= 1'b1;
    end else begin
      wd_count <= wd_count + 32'h00000001;
      wd_fire  <= 1'b0;
    end
  end

  // sticky status; set wins over write-one clear
  logic [15:0] event_status, status_set, status_view;
  always_comb begin
    status_set = event_set;
    status_set[mspi_pkg::ST_WDT] = event_set[mspi_pkg::ST_WDT] | wd_fire;
    status_set[mspi_pkg::ST_CRC] = event_set[mspi_pkg::ST_CRC] | bad_any;
  end
  always_ff @(posedge clk) begin
    if (rst || soft_rst) begin
      event_status <= mspi_pkg::ZERO_RESET;
    end else if (do_write && frame.addr == mspi_pkg::ADDR_EVENT_STATUS) begin
      event_status <= (event_status & ~frame.data) | status_set;
    end else begin
      event_status <= event_status | status_set;
    end
  end
  // live bits are levels from the datapath and never stick
  assign status_view = event_status | event_live;

  // interrupt: level latch or one pulse per new unmasked event
  // only fresh status bits count as new, so a held event pulses once
  logic [15:0] new_events;
  logic        irq_latch, irq_pulse, irq_active, status_read;
  assign new_events  = status_set & ~event_status & ~event_mask;
  assign status_read = do_read && frame.addr == mspi_pkg::ADDR_EVENT_STATUS;
  always_ff @(posedge clk) begin
    if (rst || soft_rst) begin
      irq_latch <= 1'b0;
      irq_pulse <= 1'b0;
    end else begin
      irq_pulse <= |new_events;
      if (|new_events) begin
        irq_latch <= 1'b1;
      end else if (status_read) begin
        irq_latch <= 1'b0;
      end
    end
  end
  assign irq_active = port_control[mspi_pkg::CTL_LEVEL] ? irq_latch : irq_pulse;
  // registered so the pin never glitches when polarity is rewritten
  // pulse mode keeps polarity: the pin leaves its idle level for one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b1; // idle level of the default active-low setting
    end else begin
      irq <= irq_active ^ ~port_control[mspi_pkg::CTL_POL];
    end
  end

  // read data mux
  // reserved and write-only offsets read as zero
  logic [15:0] read_data;
  always_comb begin
    case (frame.addr)
      mspi_pkg::ADDR_PORT_CONTROL: read_data = port_control;
      mspi_pkg::ADDR_EVENT_STATUS: read_data = status_view;
      mspi_pkg::ADDR_EVENT_MASK:   read_data = event_mask;
      mspi_pkg::ADDR_LINE_CONTROL: read_data = line_control;
      mspi_pkg::ADDR_RX_QUEUE:     read_data = rx_queue_data;
      mspi_pkg::ADDR_THRESHOLDS:   read_data = queue_thresholds;
      mspi_pkg::ADDR_BABBLE_LIMIT: read_data = babble_guard_limit;
      default:                     read_data = 16'h0000;
    endcase
  end

  // answer word for the next frame; crc computed over the reply
  logic [23:0] reply24;
  logic [7:0]  reply_crc;
  logic [31:0] answer; // fixed at cs rise, shown during the next frame
  assign reply24 = {frame.read, frame.addr, read_data};
  mspi_crc8 u_reply_crc (
    .word (reply24),
    .crc  (reply_crc)
  );
  always_ff @(posedge clk) begin
    if (rst) begin
      answer <= 32'h00000000;
    end else if (cs_rise) begin
      if (bad_read) begin
        answer <= mspi_pkg::BAD_CRC_WORD;
      end else if (frame.read) begin
        answer <= {reply24, reply_crc};
      end else begin
        answer <= frame; // echoes received crc too
      end
    end
  end

  // output shifter: first bit at cs fall, then one per launching sclk rise
  // the answer is loaded at cs fall, its check byte cleared when crc is off, so a frame longer than the word
  // shifts in zeros after it; that tail carries no information
  logic [31:0] shift_out;
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_out <= 32'h00000000;
    end else if (cs_fall) begin
      shift_out <= crc_on ? answer : {answer[31:8], 8'h00};
    end else if (!cs_now && sclk_rise && !lead_skip) begin
      shift_out <= {shift_out[30:0], 1'b0};
    end
  end
  // pin register; the host samples on the falling edge half a period later,
  // which covers the synchroniser and edge delay
  // the line is only meaningful while sdo_oe is high
  always_ff @(posedge clk) begin
    if (rst) begin
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo    <= shift_out[31];
      sdo_oe <= !cs_now;
    end
  end
endmodule
`default_nettype wire

// [mspi_host_model.sv]
/*
  host controller model for the spi port: drives sclk, cs_n and sdi in
  either supported clock mode, collects sdo msb first.
  assumes the bench calls xfer and that sdo is only valid while sdo_oe.
*/
`default_nettype none
module mspi_host_model (
  output var logic  sclk,
  output var logic  cs_n,
  output var logic  sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle clock level picks the mode
  logic pol = 1'b0;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  // one frame; n never below the frame length in use
  task automatic xfer(input int n, input logic [31:0] w, output logic [31:0] r);
    r = 32'h0;
    sclk = pol;
    #160 cs_n = 1'b0;
    // 160 ns half period keeps the clock and frame rate in range
    #160;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b1;
      sdi  = w[i];
      #160 sclk = 1'b0;
      // an undriven line reads as unknown so it can never match
      r = {r[30:0], sdo_oe ? sdo : 1'bx};
      #160;
    end
    sclk = pol;
    #160 cs_n = 1'b1;
    // released line must not keep the last bit
    sdi = ~sdi;
    #480;
  endtask
endmodule
`default_nettype wire

// [mspi_port_checker.sv]
/*
  pin and register assertions for the spi port.
  assumes it is bound into every instance of the port.
*/
`default_nettype none
module mspi_port_checker #(
  parameter int WD_SCALE = mspi_pkg::CYC_PER_MS // same scale as the port
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        sclk,
  input wire logic        cs_n,
  input wire logic        sdo,
  input wire logic        sdo_oe,
  input wire logic        irq,
  input wire logic        rx_queue_pop,
  input wire logic        tx_queue_push,
  input wire logic        queue_flush,
  input wire logic [15:0] port_control
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sdo_release_a: assert property (cs_n [*5] |-> !sdo_oe)
    else $error("sdo driven while deselected");
  sdo_drive_a: assert property ($fell(cs_n) |-> ##[1:6] sdo_oe)
    else $error("sdo not driven after select");
  // sdo may only move after a rising sclk or cs fall, never near the fall
  sdo_hold_a: assert property ($fell(sclk) && !cs_n |=> ($stable(sdo) || cs_n) [*3])
    else $error("sdo moved after falling sclk");
  ctl_reset_a: assert property ($past(rst) |-> port_control == 16'h8042)
    else $error("control reset value wrong");
  irq_idle_a: assert property ($past(rst) |-> irq)
    else $error("irq not idle high after reset");
  // the control register changes only once the frame has closed
  ctl_frame_a: assert property ($changed(port_control) && !$past(rst) |-> cs_n && $past(cs_n, 3))
    else $error("control changed inside a frame");
  pop_pulse_a: assert property (rx_queue_pop |-> cs_n ##1 !rx_queue_pop)
    else $error("pop not a single pulse");
  push_pulse_a: assert property (tx_queue_push |-> cs_n ##1 !tx_queue_push)
    else $error("push not a single pulse");
  flush_reset_a: assert property (queue_flush |-> port_control == 16'h8042)
    else $error("flush without control defaults");
  cover property (rx_queue_pop);
  cover property (tx_queue_push);
  cover property (queue_flush);
endmodule
bind mspi_port mspi_port_checker #(.WD_SCALE(WD_SCALE)) u_chk (.clk, .rst, .sclk, .cs_n,
  .sdo, .sdo_oe, .irq, .rx_queue_pop, .tx_queue_push, .queue_flush, .port_control);
`default_nettype wire

// [mspi_port_tb.sv]
/*
  self-checking bench for the spi port: registers, echo, crc, interrupt
  and watchdog through the host model.
  assumes a 25 mhz clock and a shortened watchdog scale of 20.
*/
`default_nettype none
module mspi_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
    $display("CHECK FAILED %0t got %h want %h", $time, (a), (b)); end end
  logic        clk = 1'b0;                 // system clock
  logic        rst = 1'b1;                 // held 20 cycles
  logic        sclk, cs_n, sdi, sdo, sdo_oe, irq, irq_q;
  logic        rx_queue_pop, tx_queue_push, queue_flush;
  logic [15:0] event_set = 16'h0000;       // event pulses
  logic [15:0] event_live = 16'h0000;      // live status levels
  logic [15:0] rx_queue_data = 16'hBEEF;   // queue head
  logic [15:0] tx_queue_data, line_control, queue_thresholds;
  logic [15:0] babble_guard_limit, port_control, pushed;
  logic [31:0] ans;                        // answer of the last frame
  int          nb = 24;                    // frame length in use
  int          bad_count = 0, cmp_count = 0, pops = 0, flushes = 0, rises = 0;
  always #20 clk = ~clk;
  // strobe and irq edge counters
  always @(posedge clk) begin
    irq_q <= irq;
    if (rx_queue_pop) pops++;
    if (queue_flush) flushes++;
    if (irq && !irq_q) rises++;
    if (tx_queue_push) pushed <= tx_queue_data;
  end
  mspi_port #(.WD_SCALE(20)) DUT (.clk, .rst, .sclk, .cs_n, .sdi, .sdo, .sdo_oe, .irq,
    .event_set, .event_live, .rx_queue_data, .rx_queue_pop, .tx_queue_push,
    .tx_queue_data, .queue_flush, .line_control, .queue_thresholds,
    .babble_guard_limit, .port_control);
  mspi_host_model host (.sclk, .cs_n, .sdi, .sdo, .sdo_oe);
  // msb first, zero seed, polynomial 0x07
  function automatic logic [7:0] crc(input logic [23:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  function automatic logic [31:0] f(input logic r, input logic [6:0] a, input logic [15:0] d);
    return (nb == 32) ? {r, a, d, crc({r, a, d})} : {8'h00, r, a, d};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    host.xfer(nb, f(1'b0, a, d), ans);
  endtask
  // answer arrives in the following frame, a control read
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    host.xfer(nb, f(1'b1, a, 16'h0000), ans);
    host.xfer(nb, f(1'b1, 7'h02, 16'h0000), ans);
    `CHK(ans, f(1'b1, a, e))
  endtask
  task automatic ev(input logic [15:0] e);
    tick(1);
    event_set = e;
    tick(1);
    event_set = 16'h0000;
    tick(8);
  endtask
  task automatic finish_test();
    if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    finish_test();
  end
  initial begin
    tick(20);
    rst = 1'b0;
    tick(4);
    rd(7'h02, 16'h8042);
    rd(7'h21, 16'hFFFF);
    rd(7'h10, 16'h0000);
    wr(7'h22, 16'h1234);
    `CHK(line_control, 16'h1234)
    host.xfer(nb, f(1'b1, 7'h02, 16'h0000), ans);
    `CHK(ans, 32'h00221234)
    // four junk bits ahead of the word
    host.xfer(28, {8'h09, 1'b0, 7'h25, 16'hA5C3}, ans);
    `CHK(queue_thresholds, 16'hA5C3)
    host.pol = 1'b1;
    wr(7'h27, 16'h0077);
    rd(7'h27, 16'h0077);
    `CHK(babble_guard_limit, 16'h0077)
    host.pol = 1'b0;
    wr(7'h23, 16'h5AA5);
    `CHK(pushed, 16'h5AA5)
    rd(7'h24, 16'hBEEF);
    // level mode, active low, only event 4 unmasked
    wr(7'h21, 16'hFFEF);
    wr(7'h02, 16'h8046);
    ev(16'h0020);
    `CHK(irq, 1'b1)
    ev(16'h0010);
    tick(20);
    `CHK(irq, 1'b0)
    event_live = 16'h0002;
    rd(7'h20, 16'h0032);
    event_live = 16'h0000;
    `CHK(irq, 1'b1)
    wr(7'h20, 16'h0030);
    wr(7'h02, 16'h804E);
    `CHK(irq, 1'b0)
    wr(7'h02, 16'h804A);
    rises = 0;
    ev(16'h0010);
    `CHK(rises, 1)
    `CHK(irq, 1'b0)
    // crc on: bad write dropped, bad read answered flat, no pop
    wr(7'h02, 16'h8052);
    nb = 32;
    wr(7'h22, 16'h00FF);
    host.xfer(nb, f(1'b0, 7'h22, 16'h0F0F) ^ 32'h1, ans);
    `CHK(ans, f(1'b0, 7'h22, 16'h00FF))
    `CHK(line_control, 16'h00FF)
    host.xfer(nb, f(1'b1, 7'h24, 16'h0000) ^ 32'h1, ans);
    host.xfer(nb, f(1'b1, 7'h02, 16'h0000), ans);
    `CHK(ans, 32'h80000000)
    `CHK(pops, 1)
    rd(7'h02, 16'h8052);
    wr(7'h07, 16'h0001);
    nb = 24;
    `CHK(port_control, 16'h8042)
    `CHK(flushes, 1)
    // watchdog 50 ms scaled to 1000 cycles, only its event unmasked
    wr(7'h21, 16'hFDFF);
    wr(7'h02, 16'h1046);
    repeat (5) host.xfer(nb, f(1'b1, 7'h02, 16'h0000), ans);
    `CHK(irq, 1'b1)
    tick(1100);
    `CHK(irq, 1'b0)
    finish_test();
  end
endmodule
`default_nettype wire
